// [design/fault_timer.sv]
/*
  Overcurrent wait and hiccup timer for one converter.
  Assumes sw_tick is a one-cycle pulse per switching cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "triple_buck_defs.svh"

module fault_timer
  import triple_buck_pkg::*;
#(
  parameter int HICCUP_CYCLES = `HICCUP_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic overcurrent,
  input  wire logic sw_tick,
  output var  logic converter_off,
  output var  logic shutdown_pulse
);

  localparam logic [8:0]  OC_LAST = 9'(`OC_WAIT_CYCLES);
  localparam logic [12:0] HC_LAST = 13'(HICCUP_CYCLES - 1);

  fault_state_type state;
  logic [8:0]      wait_cnt;
  logic [12:0]     hiccup_cnt;

  // ****************************************************************
  // Wait and hiccup sequencing
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state          <= FS_WATCH;
      wait_cnt       <= 9'h000;
      hiccup_cnt     <= 13'h0000;
      shutdown_pulse <= 1'b0;
    end else begin
      shutdown_pulse <= 1'b0;
      if (!enable) begin
        state      <= FS_WATCH;
        wait_cnt   <= 9'h000;
        hiccup_cnt <= 13'h0000;
      end else begin
        case (state)
          FS_WATCH: begin
            if (!overcurrent) begin
              wait_cnt <= 9'h000;
            end else if (sw_tick) begin
              if (wait_cnt == OC_LAST) begin
                state          <= FS_HICCUP;
                wait_cnt       <= 9'h000;
                hiccup_cnt     <= 13'h0000;
                shutdown_pulse <= 1'b1;
              end else begin
                wait_cnt <= wait_cnt + 9'h001;
              end
            end
          end
          FS_HICCUP: begin
            if (sw_tick) begin
              if (hiccup_cnt == HC_LAST) begin
                state <= FS_WATCH;
              end else begin
                hiccup_cnt <= hiccup_cnt + 13'h0001;
              end
            end
          end
          default: begin
            state <= FS_WATCH;
          end
        endcase
      end
    end
  end

  // Converter held off during hiccup
  assign converter_off = (state == FS_HICCUP);

endmodule
`default_nettype wire

// [design/triple_buck_defs.svh]
/*
  Constants of the triple buck supervisor: register offsets, field
  positions, reset values and timing counts.
  Assumes a 50 MHz core clock and a 32-bit Avalon-MM register port.
*/
// Notes on behaviour
// - Host enables each converter, sets converter two code, reads status.
// - Voltage code is 7 bits, 0.68 V upward in 10 mV steps.
// - New voltage code takes effect only after the commit bit is written.
// - Both bus lines low at start means standalone, bus writes ignored.
// - Standalone converters follow only their own enable pin.
// - Continuous conduction by default; host may enable pulse skipping.
// - Switching clock 200 kHz to 2.3 MHz; locks to sync falling edge.
// - Converter one clock is 180 degrees from converters two and three.
// - Low bootstrap pulls switch node low; full duty allowed otherwise.
// - Power good high only if all converters regulate and sequence done.
// - Host reads the power-good comparator results.
// - Overvoltage keeps high side off until feedback below 105 percent.
// - Overcurrent over 256 cycles shuts down; restart after 8192 cycles.
// - Thermal shutdown stops all; restart after 20 C drop.
// - Power good rise deglitched for 616 switching cycles.
`ifndef TRIPLE_BUCK_DEFS_SVH
`define TRIPLE_BUCK_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define REG_CTRL      8'h00
`define REG_VCODE     8'h04
`define REG_STATUS    8'h08
`define REG_IRQ_STAT  8'h0c
`define REG_IRQ_MASK  8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_EN_LSB     0
`define CTRL_PS_LSB     4
`define CTRL_COMMIT     8
`define CTRL_EN_RESET   3'h7
`define VCODE_RESET     7'h00
`define ST_PGCMP_LSB    0
`define ST_PG           3
`define ST_STANDALONE   4
`define ST_THERMAL      5
`define ST_RUN_LSB      8
`define ST_CODE_LSB     16
`define IRQ_OC_LSB      0
`define IRQ_THERMAL     3
`define IRQ_PG_RISE     4
`define IRQ_PG_FALL     5
`define IRQ_COMMIT      6
`define IRQ_WIDTH       7
`define IRQ_RESET       7'h00

// ****************************************************************
// Voltage code mapping and timing counts
// ****************************************************************
`define VCODE_BASE_MV   680
`define VCODE_STEP_MV   10
`define CORE_CLK_KHZ    50000
`define SW_MIN_KHZ      200
`define SW_MAX_KHZ      2300
`define SW_PERIOD_MAX   (`CORE_CLK_KHZ / `SW_MIN_KHZ)
`define SW_PERIOD_MIN   ((`CORE_CLK_KHZ + `SW_MAX_KHZ - 1) / `SW_MAX_KHZ)
`define SYNC_LOSS_CYCLES (2 * `SW_PERIOD_MAX)
`define OC_WAIT_CYCLES  256
`define HICCUP_CYCLES   8192
`define PG_DEGLITCH_CYCLES 616

`endif

// [design/triple_buck_pkg.sv]
/*
  Types shared by the triple buck supervisor modules.
  Assumes nothing of its surroundings.
*/
package triple_buck_pkg;

  // Overcurrent supervisor states, one-hot
  typedef enum logic [1:0] {
    FS_WATCH  = 2'b01,
    FS_HICCUP = 2'b10
  } fault_state_type;

endpackage

// [design/triple_buck_supervisor.sv]
/*
  Digital supervisor of a triple step-down converter: register port,
  enables, voltage code commit, switching phase clocks, fault handling
  and power good.
  Assumes all pin inputs synchronous to core_clk (50 MHz) and an
  Avalon-MM master on the register port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "triple_buck_defs.svh"

module triple_buck_supervisor
  import triple_buck_pkg::*;
#(
  parameter int HICCUP_CYCLES = `HICCUP_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic        irq,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [2:0]  converter_enable_pin,
  input  wire logic [7:0]  frequency_set_pin,
  input  wire logic        sync_in,
  input  wire logic [2:0]  overcurrent,
  input  wire logic [2:0]  fb_over_105,
  input  wire logic [2:0]  bootstrap_low,
  input  wire logic [2:0]  pg_compare,
  input  wire logic [2:0]  soft_start_done,
  input  wire logic        thermal_trip,
  input  wire logic        thermal_cleared,
  output var  logic [2:0]  converter_run,
  output var  logic [2:0]  high_side_allow,
  output var  logic [2:0]  switch_node_pulldown,
  output var  logic [2:0]  pulse_skip_setting,
  output var  logic [2:0]  continuous_conduction_setting,
  output var  logic        phase1_clk,
  output var  logic        phase23_clk,
  output var  logic        sw_tick,
  output var  logic [6:0]  voltage_code,
  output var  logic [10:0] target_mv,
  output var  logic        internal_divider,
  output var  logic        power_good_output,
  output var  logic        standalone
);

  // Address match, used by the write and read paths
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] offs);
    hit = (addr == offs);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                  ack;
  logic                  wr_go;
  logic [31:0]           wmask;
  logic [31:0]           wval;
  logic [2:0]            bus_enable;
  logic [2:0]            bus_skip;
  logic [6:0]            pending_code;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic                  commit_evt;
  logic                  strap_taken;
  logic                  thermal_off;
  logic                  thermal_evt;
  logic [2:0]            en_req;
  logic [2:0]            fault_off;
  logic [2:0]            oc_evt;
  logic [7:0]            period_m1;
  logic [7:0]            phase_cnt;
  logic [7:0]            sync_period;
  logic [8:0]            sync_idle;
  logic                  sync_lock;
  logic                  sync_prev;
  logic                  sync_fall;
  logic [7:0]            half_point;
  logic [9:0]            pg_cnt;
  logic                  pg_good;
  logic                  pg_prev;
  logic [31:0]           rd_mux;

  localparam logic [7:0] PMIN = 8'(`SW_PERIOD_MIN);
  localparam logic [7:0] PMAX = 8'(`SW_PERIOD_MAX);
  localparam logic [8:0] SYNC_LOSS = 9'(`SYNC_LOSS_CYCLES);
  localparam logic [9:0] PG_LAST = 10'(`PG_DEGLITCH_CYCLES);

  // ****************************************************************
  // Avalon-MM slave handshake: one wait cycle per access
  // ****************************************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack & ~standalone;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wval  = avs_writedata & wmask;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // ****************************************************************
  // Standalone strap, caught once after reset release
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken <= 1'b0;
      standalone  <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      standalone  <= ~scl_in & ~sda_in;
    end
  end

  // ****************************************************************
  // Control and voltage code registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_enable <= `CTRL_EN_RESET;
      bus_skip   <= 3'h0;
      commit_evt <= 1'b0;
    end else begin
      commit_evt <= 1'b0;
      if (wr_go && hit(avs_address, `REG_CTRL)) begin
        if (avs_byteenable[0]) begin
          bus_enable <= avs_writedata[`CTRL_EN_LSB +: 3];
          bus_skip   <= avs_writedata[`CTRL_PS_LSB +: 3];
        end
        commit_evt <= wval[`CTRL_COMMIT];
      end
    end
  end

  // Pending code only reaches the converter on commit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_code     <= `VCODE_RESET;
      voltage_code     <= `VCODE_RESET;
      internal_divider <= 1'b0;
    end else begin
      if (wr_go && hit(avs_address, `REG_VCODE) && avs_byteenable[0]) begin
        pending_code <= avs_writedata[6:0];
      end
      if (commit_evt) begin
        voltage_code     <= pending_code;
        internal_divider <= 1'b1;
      end
    end
  end

  // Linear code to millivolt mapping
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      target_mv <= 11'h000;
    end else begin
      target_mv <= 11'(`VCODE_BASE_MV) +
                   11'(voltage_code) * 11'(`VCODE_STEP_MV);
    end
  end

  // ****************************************************************
  // Switching clock: resistor period or external sync lock
  // ****************************************************************
  assign sync_fall = sync_prev & ~sync_in;

  // Clamp the resistor period into the legal frequency range
  always_comb begin
    if (frequency_set_pin < PMIN) begin
      period_m1 = PMIN - 8'h01;
    end else if (frequency_set_pin > PMAX) begin
      period_m1 = PMAX - 8'h01;
    end else begin
      period_m1 = frequency_set_pin - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_prev   <= 1'b0;
      sync_idle   <= 9'h000;
      sync_lock   <= 1'b0;
      sync_period <= PMAX;
    end else begin
      sync_prev <= sync_in;
      if (sync_fall) begin
        sync_idle   <= 9'h000;
        sync_lock   <= 1'b1;
        sync_period <= phase_cnt + 8'h01;
      end else if (sync_idle == SYNC_LOSS) begin
        sync_lock <= 1'b0;
      end else begin
        sync_idle <= sync_idle + 9'h001;
      end
    end
  end

  // Phase counter restarts on the sync falling edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_cnt <= 8'h00;
    end else if (sync_fall) begin
      phase_cnt <= 8'h00;
    end else if (!sync_lock && phase_cnt >= period_m1) begin
      phase_cnt <= 8'h00;
    end else if (phase_cnt != 8'hff) begin
      phase_cnt <= phase_cnt + 8'h01;
    end
  end

  assign half_point = sync_lock ? (sync_period >> 1)
                                : ((period_m1 + 8'h01) >> 1);

  // Opposite phases for converter one and converters two and three
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase1_clk  <= 1'b0;
      phase23_clk <= 1'b0;
      sw_tick     <= 1'b0;
    end else begin
      phase1_clk  <= (phase_cnt < half_point);
      phase23_clk <= ~(phase_cnt < half_point);
      sw_tick     <= (phase_cnt == 8'h00);
    end
  end

  // ****************************************************************
  // Thermal shutdown with automatic restart
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      thermal_off <= 1'b0;
      thermal_evt <= 1'b0;
    end else begin
      thermal_evt <= thermal_trip & ~thermal_off;
      if (thermal_trip) begin
        thermal_off <= 1'b1;
      end else if (thermal_cleared) begin
        thermal_off <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Per-converter enable, fault timer and switch gating
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : conv
      // Standalone follows the pin alone
      assign en_req[g] = strap_taken & converter_enable_pin[g] &
                         (standalone | bus_enable[g]) &
                         ~thermal_off;

      fault_timer #(
        .HICCUP_CYCLES (HICCUP_CYCLES)
      ) u_fault (
        .core_clk       (core_clk),
        .reset_n        (reset_n),
        .enable         (en_req[g]),
        .overcurrent    (overcurrent[g]),
        .sw_tick        (sw_tick),
        .converter_off  (fault_off[g]),
        .shutdown_pulse (oc_evt[g])
      );

      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          converter_run[g]        <= 1'b0;
          high_side_allow[g]      <= 1'b0;
          switch_node_pulldown[g] <= 1'b0;
        end else begin
          converter_run[g] <= en_req[g] & ~fault_off[g];
          // Overvoltage or low bootstrap blocks the high side
          high_side_allow[g] <= en_req[g] & ~fault_off[g] &
                                ~fb_over_105[g] &
                                ~bootstrap_low[g];
          switch_node_pulldown[g] <= en_req[g] & ~fault_off[g] &
                                     bootstrap_low[g];
        end
      end
    end
  endgenerate

  // Light-load mode, continuous conduction unless host asks
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_skip_setting            <= 3'h0;
      continuous_conduction_setting <= 3'h7;
    end else begin
      pulse_skip_setting <= standalone ? 3'h0 : bus_skip;
      continuous_conduction_setting <= standalone ? 3'h7 : ~bus_skip;
    end
  end

  // ****************************************************************
  // Power good with rising-edge deglitch
  // ****************************************************************
  assign pg_good = &(pg_compare & soft_start_done & converter_run);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_cnt            <= 10'h000;
      power_good_output <= 1'b0;
      pg_prev           <= 1'b0;
    end else begin
      pg_prev <= power_good_output;
      if (!pg_good) begin
        pg_cnt            <= 10'h000;
        power_good_output <= 1'b0;
      end else if (pg_cnt == PG_LAST) begin
        power_good_output <= 1'b1;
      end else if (sw_tick) begin
        pg_cnt <= pg_cnt + 10'h001;
      end
    end
  end

  // ****************************************************************
  // Interrupt status (write one to clear, set wins) and mask
  // ****************************************************************
  assign irq_set = {commit_evt, pg_prev & ~power_good_output,
                    ~pg_prev & power_good_output, thermal_evt, oc_evt};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= `IRQ_RESET;
      irq_mask   <= `IRQ_RESET;
    end else begin
      if (wr_go && hit(avs_address, `REG_IRQ_STAT)) begin
        irq_status <= (irq_status & ~wval[`IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (wr_go && hit(avs_address, `REG_IRQ_MASK)) begin
        irq_mask <= wval[`IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************************************
  // Read path, registered on the edge that ends the wait cycle
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address, `REG_CTRL)) begin
      rd_mux[`CTRL_EN_LSB +: 3] = bus_enable;
      rd_mux[`CTRL_PS_LSB +: 3] = bus_skip;
    end else if (hit(avs_address, `REG_VCODE)) begin
      rd_mux[6:0] = pending_code;
    end else if (hit(avs_address, `REG_STATUS)) begin
      rd_mux[`ST_PGCMP_LSB +: 3] = pg_compare;
      rd_mux[`ST_PG]             = power_good_output;
      rd_mux[`ST_STANDALONE]     = standalone;
      rd_mux[`ST_THERMAL]        = thermal_off;
      rd_mux[`ST_RUN_LSB +: 3]   = converter_run;
      rd_mux[`ST_CODE_LSB +: 7]  = voltage_code;
    end else if (hit(avs_address, `REG_IRQ_STAT)) begin
      rd_mux[`IRQ_WIDTH-1:0] = irq_status;
    end else if (hit(avs_address, `REG_IRQ_MASK)) begin
      rd_mux[`IRQ_WIDTH-1:0] = irq_mask;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// [testbench/buck_asserts.sv]
/* Port checker of the triple buck supervisor.
   Bound from the bench top; one clock domain, reset active low. */
`timescale 1ns/10ps
`default_nettype none
module buck_asserts (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  converter_enable_pin,
  input wire logic [2:0]  fb_over_105,
  input wire logic [2:0]  pg_compare,
  input wire logic [2:0]  soft_start_done,
  input wire logic        thermal_trip,
  input wire logic [2:0]  converter_run,
  input wire logic [2:0]  high_side_allow,
  input wire logic        phase1_clk,
  input wire logic        phase23_clk,
  input wire logic        sw_tick,
  input wire logic [6:0]  voltage_code,
  input wire logic        power_good_output
);
  logic        good;
  logic [15:0] good_ticks;
  logic [3:0]  commit_seen;
  // ****************
  // Helpers
  // ****************
  assign good = &(pg_compare & soft_start_done & converter_run);
  // Good ticks and recent commit writes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      good_ticks  <= 16'h0;
      commit_seen <= 4'h0;
    end else begin
      good_ticks  <= good ? good_ticks + {15'h0, sw_tick} : 16'h0;
      commit_seen <= {commit_seen[2:0], avs_write && !avs_waitrequest
                      && avs_address == 8'h00 && avs_writedata[8]};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  bus_wait_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait not one cycle");
  phase_split_a: assert property (
    $rose(phase1_clk) |-> sw_tick && !phase23_clk)
    else $error("phase clocks not opposed");
  hs_block_a: assert property (1'b1 |=>
    (high_side_allow & $past(fb_over_105)) == 3'h0)
    else $error("high side on during overvoltage");
  pg_drop_a: assert property (!good |=> !power_good_output)
    else $error("power good high while not good");
  pg_hold_a: assert property (
    $rose(power_good_output) |-> good_ticks >= 16'd616)
    else $error("power good rose too early");
  run_pin_a: assert property (
    (converter_run & ~$past(converter_enable_pin)) == 3'h0)
    else $error("converter runs with pin low");
  thermal_stop_a: assert property (
    thermal_trip |-> ##3 converter_run == 3'h0)
    else $error("converters run after thermal trip");
  commit_gate_a: assert property (
    $changed(voltage_code) |-> commit_seen != 4'h0)
    else $error("code changed without commit");
  cover property ($rose(power_good_output));
  cover property ($fell(converter_run[0]));
  cover property ($changed(voltage_code));
endmodule
`default_nettype wire

// [testbench/buck_plant.sv]
/* Analog side of the three converters as seen by the supervisor.
   Assumes run levels from the supervisor on core_clk. */
`timescale 1ns/10ps
`default_nettype none
module buck_plant (
  input  wire logic       core_clk,
  input  wire logic [2:0] converter_run,
  input  wire logic [2:0] force_bad,
  output var  logic [2:0] pg_compare,
  output var  logic [2:0] soft_start_done
);
  // Outputs regulate one cycle after switching starts
  always_ff @(posedge core_clk) begin
    soft_start_done <= converter_run;
    pg_compare      <= converter_run & ~force_bad;
  end
endmodule
`default_nettype wire

// [testbench/triple_buck_supervisor_tb_top.sv]
/* Self-checking bench of the triple buck supervisor.
   Assumes the design, plant model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module triple_buck_supervisor_tb_top;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
  logic scl_in, sda_in, sync_in, thermal_trip, thermal_cleared, sw_tick;
  logic phase1_clk, phase23_clk, internal_divider, standalone;
  logic power_good_output;
  logic [7:0]  avs_address, frequency_set_pin;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [2:0]  converter_enable_pin, overcurrent, fb_over_105, force_bad;
  logic [2:0]  bootstrap_low, pg_compare, soft_start_done, converter_run;
  logic [2:0]  high_side_allow, switch_node_pulldown, pulse_skip_setting;
  logic [2:0]  continuous_conduction_setting;
  logic [6:0]  voltage_code;
  logic [10:0] target_mv;
  int          err_total, checks, n;
  triple_buck_supervisor #(.HICCUP_CYCLES(8)) dut (.*);
  buck_plant plant (.core_clk(core_clk), .converter_run(converter_run),
    .force_bad(force_bad), .pg_compare(pg_compare),
    .soft_start_done(soft_start_done));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    chk(k < 20, 32'h1);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic do_reset(input logic strap);
    reset_n <= 1'b0;
    scl_in  <= strap;
    sda_in  <= strap;
    cyc(10);
    reset_n <= 1'b1;
    cyc(3);
  endtask
  task automatic wait_run0(input logic v, input int lim);
    n = 0;
    while (converter_run[0] !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs_ctrl;
    bus(0, 8'h00, 0);
    chk(rd, 32'h7);
    bus(0, 8'h14, 0);
    chk(rd, 32'h0);
    bus(1, 8'h00, 32'h15);
    cyc(3);
    chk(converter_run, 3'b101);
    chk(pulse_skip_setting, 3'b001);
    chk(continuous_conduction_setting, 3'b110);
    $display("test regs_ctrl done");
  endtask
  task automatic t_commit;
    bus(1, 8'h04, 32'h7f);
    bus(1, 8'h10, 32'h41);
    cyc(4);
    chk(voltage_code, 7'h00);
    bus(1, 8'h00, 32'h107);
    cyc(3);
    chk(voltage_code, 7'h7f);
    chk(target_mv, 11'd1950);
    chk(internal_divider, 1'b1);
    chk(irq, 1'b1);
    bus(0, 8'h08, 0);
    chk(rd[22:16], 7'h7f);
    bus(1, 8'h0c, 32'h40);
    chk(irq, 1'b0);
    $display("test commit done");
  endtask
  task automatic t_power_good_output;
    force_bad <= 3'h7;
    cyc(3);
    chk(power_good_output, 1'b0);
    force_bad <= 3'h0;
    n = 0;
    while (power_good_output !== 1'b1 && n < 14000) begin
      cyc(1);
      n++;
    end
    chk(n >= 615 * 22 && n < 617 * 22 + 10, 32'h1);
    bus(0, 8'h08, 0);
    chk(rd[3:0], 4'hf);
    force_bad <= 3'h2;
    cyc(3);
    chk(power_good_output, 1'b0);
    force_bad <= 3'h0;
    $display("test power_good_output done");
  endtask
  task automatic t_guard;
    fb_over_105   <= 3'b010;
    bootstrap_low <= 3'b100;
    cyc(3);
    chk(high_side_allow[1:0], 2'b01);
    chk(switch_node_pulldown, 3'b100);
    fb_over_105   <= 3'b000;
    bootstrap_low <= 3'b000;
    cyc(3);
    chk(high_side_allow, 3'b111);
    $display("test guard done");
  endtask
  task automatic t_ocp;
    overcurrent <= 3'b001;
    cyc(2000);
    overcurrent <= 3'b000;
    cyc(30);
    overcurrent <= 3'b001;
    wait_run0(1'b0, 6000);
    chk(n >= 255 * 22 && n < 258 * 22 + 10, 32'h1);
    overcurrent <= 3'b000;
    chk(irq, 1'b1);
    wait_run0(1'b1, 400);
    chk(n >= 7 * 22 && n < 9 * 22 + 10, 32'h1);
    bus(1, 8'h0c, 32'h01);
    chk(irq, 1'b0);
    $display("test ocp done");
  endtask
  task automatic t_thermal;
    thermal_trip <= 1'b1;
    cyc(1);
    thermal_trip <= 1'b0;
    cyc(4);
    chk(converter_run, 3'b000);
    thermal_cleared <= 1'b1;
    cyc(4);
    chk(converter_run, 3'b111);
    thermal_cleared <= 1'b0;
    $display("test thermal done");
  endtask
  task automatic t_alone;
    do_reset(1'b0);
    converter_enable_pin <= 3'b011;
    bus(1, 8'h00, 32'h0);
    cyc(3);
    chk(converter_run, 3'b011);
    bus(0, 8'h08, 0);
    chk(rd[4], 1'b1);
    sync_in <= 1'b1;
    cyc(1);
    sync_in <= 1'b0;
    cyc(3);
    chk(sw_tick, 1'b1);
    $display("test alone done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    cyc(60000);
    err_total++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    {reset_n, avs_read, avs_write, sync_in, thermal_trip} = 5'h0;
    {thermal_cleared, scl_in, sda_in} = 3'h3;
    {overcurrent, fb_over_105, bootstrap_low, force_bad} = 12'h0;
    avs_address          = 8'h00;
    avs_writedata        = 32'h0;
    avs_byteenable       = 4'hf;
    frequency_set_pin    = 8'd22;
    converter_enable_pin = 3'h7;
    @(posedge core_clk);
    do_reset(1'b1);
    t_regs_ctrl;
    t_commit;
    t_power_good_output;
    t_guard;
    t_ocp;
    t_thermal;
    t_alone;
    report_and_stop;
  end
endmodule
bind triple_buck_supervisor buck_asserts asserts_i (.*);
`default_nettype wire
